// ===== rtl/lhd_fifo_mem.sv
`timescale 1ns/10ps
// ****************************************************************
// dejitter storage, registered read
// ****************************************************************
module lhd_fifo_mem (
    input wire logic ref_clk,
    input wire logic writeEn,
    input wire logic [lhd_pkg::FIFO_AW-1:0] writeAddr,
    input wire logic writeBit,
    input wire logic readEn,
    input wire logic [lhd_pkg::FIFO_AW-1:0] readAddr,
    output logic readBit
);
    logic [(1 << lhd_pkg::FIFO_AW)-1:0] store;

    // no reset: contents are only read after a write fills them
    always_ff @(posedge ref_clk) begin
        if (writeEn) begin
            store[writeAddr] <= writeBit;
        end
        if (readEn) begin
            readBit <= store[readAddr];
        end
    end
endmodule

// ===== rtl/lhd_host_regs.sv
`timescale 1ns/10ps
// Operation
// - host registers only while mode pin high
// - port: shift clock, in, out, select, interrupt
// - interrupt pin low reports alarms
// - host mode ignores hardware configuration pins except the transmit pin
// - five shared pins change function by mode
// - transmit pin gates drivers when bit set
// - dejitter timing from reference clock only
// - path select puts fifo in rx/tx
// - size selects pick 16, 32 or off
// - write on path clock, read dejittered
// - margin alarm within two bits of limits
// - reading margin alarm resets fifo and bit
// - dejitter register bit positions
// - event register clears on read, fixed fields
// - enables gate events; fifo enable needs dejitter
// - status change sets event, read clears
module lhd_host_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hostHardwareSelect,
    input wire logic deviceSelect_n,
    input wire logic shiftClock,
    input wire logic serialInLine,
    input wire logic serialOutLineIn,
    output logic serialOutLineOut,
    output logic serialOutLineOe,
    input wire logic interruptLineIn,
    output logic interruptLineOut,
    output logic interruptLineOe,
    input wire logic transmitDriverOnPin,
    input wire logic dejitterPathPin,
    input wire logic fifoSizeSelLoPin,
    input wire logic fifoSizeSelHiPin,
    input wire logic driverMonitorFault,
    input wire logic receiveSignalLoss,
    input wire logic receiveLockLoss,
    input wire logic analogSignalLoss,
    input wire logic patternLockLoss,
    input wire logic patternErrorPulse,
    input wire logic countSaturatedPulse,
    input wire logic transmitLineClock,
    input wire logic transmitLineData,
    input wire logic recoveredLineClock,
    input wire logic recoveredLineData,
    output logic transmitDriverOn,
    output logic receiverPowerOn,
    output logic receiveClockInvert,
    output logic transmitClockInvert,
    output logic monitorGainMode,
    output logic lossDataMute,
    output logic dejitterPathSelect,
    output logic dejitteredClock,
    output logic dejitteredData,
    output logic [7:0] transmitControl,
    output logic [7:0] blockControl
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    localparam int NSYNC = 19;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    wire [NSYNC-1:0] pinsRaw = {hostHardwareSelect, deviceSelect_n, shiftClock, serialInLine,
        serialOutLineIn, interruptLineIn, transmitDriverOnPin, dejitterPathPin, fifoSizeSelLoPin,
        fifoSizeSelHiPin, driverMonitorFault, receiveSignalLoss, receiveLockLoss, analogSignalLoss,
        patternLockLoss, transmitLineClock, transmitLineData, recoveredLineClock, recoveredLineData};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                end else begin
                    syncA[gi] <= pinsRaw[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    wire hostMode, selN, sclk, serial_in_line, sdoPin, intPin, txOnPin, pathPin, loPin, hiPin;
    wire driver_monitor_fault, receive_signal_loss, receive_lock_loss, alos, plos, transmit_line_clock, txData, recovered_line_clock, rxData;
    assign {hostMode, selN, sclk, serial_in_line, sdoPin, intPin, txOnPin, pathPin, loPin, hiPin,
        driver_monitor_fault, receive_signal_loss, receive_lock_loss, alos, plos, transmit_line_clock, txData, recovered_line_clock, rxData} = syncB;

    // ****************************************************************
    // register bank
    // ****************************************************************
    logic [7:0] linePower, intEnable, events, receiveControl, dejitterCtrl;
    logic flAlarm;
    lhd_pkg::lhd_access_t access;
    logic accessValid, readRequest, portOut, portDrive;
    wire [7:0] readData;

    lhd_serial_port u_port (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(hostMode && !selN),
        .shiftClock(sclk),
        .serialIn(serial_in_line),
        .readData(readData),
        .access(access),
        .accessValid(accessValid),
        .readRequest(readRequest),
        .serialOut(portOut),
        .serialDrive(portDrive)
    );

    function automatic logic hit(input lhd_pkg::lhd_access_t a, input logic [5:0] offset);
        hit = a.addr == offset;
    endfunction

    wire writeStrobe = accessValid && access.write;
    wire eventRead = readRequest && hit(access, lhd_pkg::REG_EVENTS);
    wire alarmRead = readRequest && hit(access, lhd_pkg::REG_ALARMS);
    wire [7:0] alarmStatus = {2'b00, plos, alos, flAlarm, receive_lock_loss, receive_signal_loss, driver_monitor_fault};
    assign readData = hit(access, lhd_pkg::REG_LINE_POWER) ? linePower :
        hit(access, lhd_pkg::REG_INT_ENABLE) ? intEnable :
        hit(access, lhd_pkg::REG_EVENTS) ? events :
        hit(access, lhd_pkg::REG_ALARMS) ? alarmStatus :
        hit(access, lhd_pkg::REG_TX_CTRL) ? transmitControl :
        hit(access, lhd_pkg::REG_RX_CTRL) ? receiveControl :
        hit(access, lhd_pkg::REG_BLOCK_CTRL) ? blockControl :
        hit(access, lhd_pkg::REG_DEJITTER) ? dejitterCtrl : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            linePower <= lhd_pkg::RESET_VALUE;
            intEnable <= lhd_pkg::RESET_VALUE;
            transmitControl <= lhd_pkg::RESET_VALUE;
            receiveControl <= lhd_pkg::RESET_VALUE;
            blockControl <= lhd_pkg::RESET_VALUE;
            dejitterCtrl <= lhd_pkg::RESET_VALUE;
        end else if (writeStrobe) begin
            if (hit(access, lhd_pkg::REG_LINE_POWER)) linePower <= access.data & lhd_pkg::MASK_LINE_POWER;
            if (hit(access, lhd_pkg::REG_INT_ENABLE)) intEnable <= access.data & lhd_pkg::MASK_INT_ENABLE;
            if (hit(access, lhd_pkg::REG_TX_CTRL)) transmitControl <= access.data & lhd_pkg::MASK_TX_CTRL;
            if (hit(access, lhd_pkg::REG_RX_CTRL)) receiveControl <= access.data & lhd_pkg::MASK_RX_CTRL;
            if (hit(access, lhd_pkg::REG_BLOCK_CTRL)) blockControl <= access.data & lhd_pkg::MASK_BLOCK_CTRL;
            if (hit(access, lhd_pkg::REG_DEJITTER)) dejitterCtrl <= access.data & lhd_pkg::MASK_DEJITTER;
        end
    end

    // ****************************************************************
    // mode-dependent configuration
    // ****************************************************************
    // hardware-mode pins other than the transmit pin are simply not looked at in host mode
    wire [1:0] sizeSel = hostMode ? {dejitterCtrl[lhd_pkg::DJ_SIZE_HI], dejitterCtrl[lhd_pkg::DJ_SIZE_LO]}
        : {hiPin, loPin};
    wire pathTx = hostMode ? dejitterCtrl[lhd_pkg::DJ_PATH] : pathPin;
    wire next_transmit_driver_on = hostMode ? (linePower[lhd_pkg::LP_TX_ON] & txOnPin) : txOnPin;
    wire next_receiver_power_on = hostMode ? linePower[lhd_pkg::LP_RX_ON] : serial_in_line;
    wire next_rxInv = hostMode ? receiveControl[lhd_pkg::RX_CLK_INV] : selN;
    wire next_txInv = hostMode ? transmitControl[lhd_pkg::TX_CLK_INV] : sclk;
    wire next_mon = hostMode ? receiveControl[lhd_pkg::RX_MON] : sdoPin;
    wire next_mute = hostMode ? receiveControl[lhd_pkg::RX_MUTE] : intPin;

    function automatic logic [5:0] fifoDepth(input logic [1:0] sel);
        case (sel)
            2'b00: fifoDepth = 6'h00;
            2'b01: fifoDepth = lhd_pkg::FIFO_SMALL;
            default: fifoDepth = lhd_pkg::FIFO_LARGE;
        endcase
    endfunction

    wire [5:0] depth = fifoDepth(sizeSel);
    wire dejOff = depth == 6'h00;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmitDriverOn <= 1'b0;
            receiverPowerOn <= 1'b0;
            receiveClockInvert <= 1'b0;
            transmitClockInvert <= 1'b0;
            monitorGainMode <= 1'b0;
            lossDataMute <= 1'b0;
            dejitterPathSelect <= 1'b0;
        end else begin
            transmitDriverOn <= next_transmit_driver_on;
            receiverPowerOn <= next_receiver_power_on;
            receiveClockInvert <= next_rxInv;
            transmitClockInvert <= next_txInv;
            monitorGainMode <= next_mon;
            lossDataMute <= next_mute;
            dejitterPathSelect <= pathTx;
        end
    end

    // ****************************************************************
    // dejitter fifo
    // ****************************************************************
    logic [lhd_pkg::FIFO_AW-1:0] wrPtr, rdPtr;
    logic [5:0] fill;
    logic [3:0] divCount;
    logic centred, pathClkPrev, readPending, memBit;
    logic [1:0] sizePrev;
    wire pathClk = pathTx ? transmit_line_clock : recovered_line_clock;
    wire pathData = pathTx ? txData : rxData;
    // a size change restarts the fifo so the fill never sits beyond the new depth
    wire flush = dejOff || (hostMode && dejitterCtrl[lhd_pkg::DJ_PTR_RST]) || alarmRead
        || sizeSel != sizePrev;
    wire divTick = divCount == lhd_pkg::DEJ_DIV - 4'h1;
    wire writeEn = pathClk && !pathClkPrev && !flush && fill < depth;
    wire readEn = divTick && centred && fill != 6'h00 && !flush;
    wire [5:0] next_fill = fill + {5'h00, writeEn} - {5'h00, readEn};
    wire [lhd_pkg::FIFO_AW-1:0] lastSlot = lhd_pkg::FIFO_AW'(depth - 6'h01);
    wire limit = centred && (fill >= depth - lhd_pkg::FIFO_MARGIN || fill <= lhd_pkg::FIFO_MARGIN);

    lhd_fifo_mem u_mem (
        .ref_clk(ref_clk),
        .writeEn(writeEn),
        .writeAddr(wrPtr),
        .writeBit(pathData),
        .readEn(readEn),
        .readAddr(rdPtr),
        .readBit(memBit)
    );

    // read pace comes from the reference divider, never from the line clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= 4'h0;
        end else begin
            divCount <= divTick ? 4'h0 : divCount + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill <= 6'h00;
            centred <= 1'b0;
            pathClkPrev <= 1'b0;
            sizePrev <= 2'b00;
        end else begin
            pathClkPrev <= pathClk;
            sizePrev <= sizeSel;
            if (flush) begin
                wrPtr <= '0;
                rdPtr <= '0;
                fill <= 6'h00;
                centred <= 1'b0;
            end else begin
                if (writeEn) wrPtr <= wrPtr == lastSlot ? '0 : wrPtr + 1'b1;
                if (readEn) rdPtr <= rdPtr == lastSlot ? '0 : rdPtr + 1'b1;
                fill <= next_fill;
                // reads wait until half full so jitter has room both ways
                if (fill >= depth >> 1) centred <= 1'b1;
            end
        end
    end

    // bypass when off; otherwise a half-duty clock beside each read bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            readPending <= 1'b0;
            dejitteredClock <= 1'b0;
            dejitteredData <= 1'b0;
        end else if (dejOff) begin
            readPending <= 1'b0;
            dejitteredClock <= pathClk;
            dejitteredData <= pathData;
        end else begin
            readPending <= readEn;
            if (readPending) dejitteredData <= memBit;
            if (readPending) dejitteredClock <= 1'b1;
            else if (divCount == lhd_pkg::DEJ_DIV >> 1) dejitteredClock <= 1'b0;
        end
    end

    // ****************************************************************
    // alarm, events and interrupt
    // ****************************************************************
    logic [3:0] statusPrev;
    logic intDrive;
    wire [3:0] statusNow = {flAlarm, receive_lock_loss, receive_signal_loss, driver_monitor_fault};
    wire [7:0] eventSet = {2'b00, countSaturatedPulse, patternErrorPulse, statusNow ^ statusPrev};
    wire [7:0] enMask = intEnable & ~({7'h00, dejOff} << lhd_pkg::EV_FIFO);
    wire intActive = |(events & enMask);

    // a set in the same cycle as the clearing read survives
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flAlarm <= 1'b0;
            statusPrev <= 4'h0;
            events <= lhd_pkg::RESET_VALUE;
            intDrive <= 1'b0;
        end else begin
            flAlarm <= limit || (flAlarm && !alarmRead);
            statusPrev <= statusNow;
            events <= eventSet | (eventRead ? 8'h00 : events);
            intDrive <= hostMode && intActive;
        end
    end

    // both shared outputs only ever drive in host mode
    assign interruptLineOut = 1'b0;
    assign interruptLineOe = intDrive;
    assign serialOutLineOut = portOut;
    assign serialOutLineOe = hostMode && portDrive;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_tx_gate_off: assert property (hostMode && !linePower[lhd_pkg::LP_TX_ON] |=> !transmitDriverOn)
        else $error("transmit driver on with host bit clear");
    a_hw_rx_pin: assert property (!hostMode && $stable(hostMode) |=> receiverPowerOn == $past(serial_in_line))
        else $error("receiver power not following shared pin");
    a_int_raise: assert property (hostMode && intActive |=> interruptLineOe && !interruptLineOut)
        else $error("interrupt not driven low for pending event");
    a_int_release: assert property (!intActive |=> !interruptLineOe)
        else $error("interrupt held without enabled event");
    a_event_set: assert property (statusNow[lhd_pkg::EV_SIG_LOSS] != statusPrev[lhd_pkg::EV_SIG_LOSS]
        |=> events[lhd_pkg::EV_SIG_LOSS])
        else $error("signal loss change not recorded");
    a_event_clear: assert property (eventRead && eventSet == 8'h00 |=> events == 8'h00)
        else $error("event register not cleared by read");
    a_flush_read: assert property (alarmRead |=> fill == 6'h00 && !centred)
        else $error("alarm read did not reset fifo");
    a_limit_flag: assert property (limit |=> flAlarm)
        else $error("margin alarm missed");
    a_fill_bound: assert property (fill <= depth || $changed(sizeSel))
        else $error("fill beyond selected depth");
    a_fie_ignored: assert property (dejOff |-> !enMask[lhd_pkg::EV_FIFO])
        else $error("fifo event enabled while dejitter off");
    a_path_reg: assert property ((hostMode && $stable(dejitterCtrl)) [*2] |-> dejitterPathSelect ==
        dejitterCtrl[lhd_pkg::DJ_PATH])
        else $error("path select not from register");
    a_read_pace: assert property (readEn |-> divTick ##1 !readEn [*7])
        else $error("dejitter reads faster than divider");

    c_write: cover property (writeStrobe);
    c_event_read: cover property (eventRead && events != 8'h00);
    c_alarm: cover property (!flAlarm ##1 flAlarm);
    c_int: cover property (!interruptLineOe ##1 interruptLineOe);
endmodule

// ===== rtl/lhd_pkg.sv
// ****************************************************************
// shared constants and types
// ****************************************************************
package lhd_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] REG_LINE_POWER = 6'h00;
    localparam logic [5:0] REG_INT_ENABLE = 6'h01;
    localparam logic [5:0] REG_EVENTS = 6'h02;
    localparam logic [5:0] REG_ALARMS = 6'h03;
    localparam logic [5:0] REG_TX_CTRL = 6'h04;
    localparam logic [5:0] REG_RX_CTRL = 6'h05;
    localparam logic [5:0] REG_BLOCK_CTRL = 6'h06;
    localparam logic [5:0] REG_DEJITTER = 6'h07;
    localparam logic [7:0] MASK_LINE_POWER = 8'h11;
    localparam logic [7:0] MASK_INT_ENABLE = 8'h3F;
    localparam logic [7:0] MASK_TX_CTRL = 8'h17;
    localparam logic [7:0] MASK_RX_CTRL = 8'h1F;
    localparam logic [7:0] MASK_BLOCK_CTRL = 8'h3F;
    localparam logic [7:0] MASK_DEJITTER = 8'h0F;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int LP_TX_ON = 0;
    localparam int LP_RX_ON = 4;
    localparam int EV_DRIVER = 0;
    localparam int EV_SIG_LOSS = 1;
    localparam int EV_LOCK_LOSS = 2;
    localparam int EV_FIFO = 3;
    localparam int EV_PATTERN = 4;
    localparam int EV_COUNT_SAT = 5;
    localparam int TX_CLK_INV = 1;
    localparam int RX_MON = 1;
    localparam int RX_MUTE = 2;
    localparam int RX_CLK_INV = 3;
    localparam int DJ_SIZE_LO = 0;
    localparam int DJ_PATH = 1;
    localparam int DJ_SIZE_HI = 2;
    localparam int DJ_PTR_RST = 3;
    localparam int FIFO_AW = 5;
    localparam logic [5:0] FIFO_SMALL = 6'h10;
    localparam logic [5:0] FIFO_LARGE = 6'h20;
    localparam logic [5:0] FIFO_MARGIN = 6'h02;
    localparam int REF_CLK_NS = 100;
    localparam int DEJ_PERIOD_NS = 800;
    localparam logic [3:0] DEJ_DIV = 4'(DEJ_PERIOD_NS / REF_CLK_NS);
    localparam logic [4:0] HEADER_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h0F;
    localparam logic [4:0] FRAME_DONE = 5'h10;
    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic [7:0] data;
    } lhd_access_t;
endpackage

// ===== rtl/lhd_serial_port.sv
`timescale 1ns/10ps
// ****************************************************************
// serial host port: flag, address, eight data bits, lsb first
// ****************************************************************
module lhd_serial_port (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic shiftClock,
    input wire logic serialIn,
    input wire logic [7:0] readData,
    output lhd_pkg::lhd_access_t access,
    output logic accessValid,
    output logic readRequest,
    output logic serialOut,
    output logic serialDrive
);
    logic sclkPrev;
    logic [4:0] bitCount;
    logic [7:0] header;
    logic [7:0] dataShift;
    logic [7:0] outShift;
    wire rise = shiftClock & ~sclkPrev;
    wire fall = ~shiftClock & sclkPrev;
    wire inHeader = bitCount <= lhd_pkg::HEADER_LAST;
    wire [7:0] next_header = {serialIn, header[7:1]};
    wire [7:0] next_data = {serialIn, dataShift[7:1]};

    // header bit 0 high means read
    assign access = '{write: ~header[0], addr: header[6:1], data: dataShift};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev <= 1'b0;
            bitCount <= 5'h00;
            header <= 8'h00;
            dataShift <= 8'h00;
            accessValid <= 1'b0;
            readRequest <= 1'b0;
        end else begin
            sclkPrev <= shiftClock;
            accessValid <= 1'b0;
            readRequest <= 1'b0;
            if (!enable) begin
                bitCount <= 5'h00;
            end else if (rise && bitCount != lhd_pkg::FRAME_DONE) begin
                bitCount <= bitCount + 5'h01;
                if (inHeader) begin
                    header <= next_header;
                end else begin
                    dataShift <= next_data;
                end
                readRequest <= bitCount == lhd_pkg::HEADER_LAST && next_header[0];
                accessValid <= bitCount == lhd_pkg::FRAME_LAST && !header[0];
            end
        end
    end

    // read data leaves on falling edges so the host samples on rising ones
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            outShift <= 8'h00;
            serialOut <= 1'b0;
            serialDrive <= 1'b0;
        end else if (!enable) begin
            serialDrive <= 1'b0;
        end else if (readRequest) begin
            outShift <= readData;
            serialDrive <= 1'b1;
        end else if (fall && serialDrive) begin
            serialOut <= outShift[0];
            outShift <= {1'b0, outShift[7:1]};
        end
    end
endmodule

// ===== tb/lhd_host_model.sv
`timescale 1ns/10ps
// ****************************************************************
// serial host processor model
// ****************************************************************
module lhd_host_model (
    input wire logic ref_clk,
    input wire logic serialOut,
    output logic deviceSelect_n,
    output logic shiftClock,
    output logic serialInLine
);
    initial begin
        deviceSelect_n = 1'b1;
        shiftClock = 1'b0;
        serialInLine = 1'b0;
    end
    // flag, address, data lsb first; clock parks low between frames
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {d, 1'b0, a, rd};
        q = 8'h00;
        @(posedge ref_clk) deviceSelect_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk) shiftClock <= 1'b0;
            serialInLine <= f[i];
            repeat (4) @(posedge ref_clk);
            shiftClock <= 1'b1;
            if (i > 7) q[i-8] = serialOut;
            repeat (3) @(posedge ref_clk);
        end
        @(posedge ref_clk) shiftClock <= 1'b0;
        repeat (4) @(posedge ref_clk);
        deviceSelect_n <= 1'b1;
        // released line: show the inverse so a stale value cannot pass
        serialInLine <= ~serialInLine;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// ===== tb/liu_host_regs_dejitter_fifo_bench.sv
`timescale 1ns/10ps
module liu_host_regs_dejitter_fifo_bench;
    logic ref_clk, rst_n, hostSel, txPin, pathPin, drvFault, sigLoss, aLoss, pLock, patPulse, satPulse, lLoss;
    logic transmit_line_clock, txData, recovered_line_clock, rxData, selN, sck, serial_in_line, sdoOut, sdoOe, intOut, intOe, sdoWire, intWire;
    logic transmit_driver_on, receiver_power_on, rxInv, txInv, pathSel, djClk;
    logic [7:0] q;
    integer seed = 32'hdeb6;
    int err_count = 0;
    int checks = 0;
    // open-drain and shared lines are pulled up when nobody drives them
    assign sdoWire = sdoOe ? sdoOut : 1'b1;
    assign intWire = intOe ? intOut : 1'b1;
    lhd_host_model host (.ref_clk(ref_clk), .serialOut(sdoWire), .deviceSelect_n(selN), .shiftClock(sck),
        .serialInLine(serial_in_line));
    lhd_host_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .hostHardwareSelect(hostSel), .deviceSelect_n(selN),
        .shiftClock(sck), .serialInLine(serial_in_line), .serialOutLineIn(sdoWire), .serialOutLineOut(sdoOut),
        .serialOutLineOe(sdoOe), .interruptLineIn(intWire), .interruptLineOut(intOut), .interruptLineOe(intOe),
        .transmitDriverOnPin(txPin), .dejitterPathPin(pathPin), .fifoSizeSelLoPin(1'b0), .fifoSizeSelHiPin(1'b0),
        .driverMonitorFault(drvFault), .receiveSignalLoss(sigLoss), .receiveLockLoss(lLoss),
        .analogSignalLoss(aLoss), .patternLockLoss(pLock), .patternErrorPulse(patPulse),
        .countSaturatedPulse(satPulse), .transmitLineClock(transmit_line_clock), .transmitLineData(txData),
        .recoveredLineClock(recovered_line_clock), .recoveredLineData(rxData), .transmitDriverOn(transmit_driver_on), .receiverPowerOn(receiver_power_on),
        .receiveClockInvert(rxInv), .transmitClockInvert(txInv), .monitorGainMode(), .lossDataMute(),
        .dejitterPathSelect(pathSel), .dejitteredClock(djClk), .dejitteredData(), .transmitControl(),
        .blockControl());
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        recovered_line_clock = 1'b0;
        #37;
        forever #400 recovered_line_clock = ~recovered_line_clock;
    end
    assign transmit_line_clock = ~recovered_line_clock;
    always @(posedge ref_clk) begin
        rxData <= $random(seed);
        txData <= $random(seed);
    end
    function automatic logic [7:0] mask_of(input int a);
        case (a)
            0: mask_of = lhd_pkg::MASK_LINE_POWER;
            1: mask_of = lhd_pkg::MASK_INT_ENABLE;
            4: mask_of = lhd_pkg::MASK_TX_CTRL;
            5: mask_of = lhd_pkg::MASK_RX_CTRL;
            6: mask_of = lhd_pkg::MASK_BLOCK_CTRL;
            7: mask_of = lhd_pkg::MASK_DEJITTER;
            default: mask_of = 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic wrap_up;
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_count++;
        wrap_up();
    end
    initial begin
        logic [7:0] d;
        {rst_n, txPin, pathPin, drvFault, sigLoss, aLoss, pLock, patPulse, satPulse, lLoss} = '0;
        hostSel = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // write then read every place, unmapped 0x2A last
        for (int a = 0; a < 9; a++) begin
            d = $random(seed);
            wr((a == 8) ? 6'h2A : 6'(a), d);
            host.xfer(1'b1, (a == 8) ? 6'h2A : 6'(a), 8'h00, q);
            chk(q, d & mask_of(a));
        end
        wr(7, 8'h00);
        // the random dejitter setting may have left the margin alarm set
        host.xfer(1'b1, 6'h03, 8'h00, q);
        repeat (20) @(posedge ref_clk);
        host.xfer(1'b1, 6'h02, 8'h00, q);
        wr(1, 8'h3F);
        sigLoss <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({7'h0, intWire}, 8'h00);
        host.xfer(1'b1, 6'h02, 8'h00, q);
        chk(q, 8'h02);
        host.xfer(1'b1, 6'h03, 8'h00, q);
        chk(q, 8'h02);
        chk({7'h0, intWire}, 8'h01);
        wr(1, 8'h00);
        {drvFault, lLoss} <= 2'b11;
        {satPulse, patPulse} <= 2'b11;
        @(posedge ref_clk) {satPulse, patPulse} <= 2'b00;
        repeat (8) @(posedge ref_clk);
        chk({7'h0, intWire}, 8'h01);
        host.xfer(1'b1, 6'h02, 8'h00, q);
        chk(q, 8'h35);
        for (int i = 0; i < 4; i++) begin
            wr(0, {7'h0, i[1]});
            txPin <= i[0];
            repeat (6) @(posedge ref_clk);
            chk({7'h0, transmit_driver_on}, {7'h0, i[1] & i[0]});
        end
        // small fifo on receive path; pin must not steer it in host mode
        pathPin <= 1'b1;
        wr(7, 8'h01);
        chk({7'h0, pathSel}, 8'h00);
        d = 8'h00;
        for (int n = 0; n < 400 && d == 8'h00; n++) begin
            @(posedge ref_clk);
            d = {7'h0, djClk === 1'b1};
        end
        chk(d, 8'h01);
        // mid-run reset must bring the dejitter register back to zero
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        host.xfer(1'b1, 6'h07, 8'h00, q);
        chk(q, 8'h00);
        hostSel <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk({4'h0, rxInv, txInv, receiver_power_on, pathSel}, {4'h0, selN, sck, serial_in_line, 1'b1});
        wrap_up();
    end
endmodule
